// ---- design/pwm_pair_pkg.sv ----
// constants and carrier types for the pulse-pair compare stage
package pwm_pair_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_PAIR1_FIRST  = 32'hffff0f94;
  localparam logic [31:0] ADDR_PAIR1_SECOND = 32'hffff0f98;
  localparam logic [31:0] ADDR_PAIR1_THIRD  = 32'hffff0f9c;
  localparam logic [31:0] ADDR_PAIR1_LENGTH = 32'hffff0fa0;
  localparam logic [31:0] ADDR_PAIR2_FIRST  = 32'hffff0fa4;
  localparam logic [31:0] ADDR_PAIR2_SECOND = 32'hffff0fa8;
  localparam logic [31:0] ADDR_PAIR2_THIRD  = 32'h0fff0fac;
  localparam logic [31:0] ADDR_PAIR2_LENGTH = 32'hffff0fb0;
  localparam logic [31:0] ADDR_OUT_STATUS   = 32'hffff0fb4;
  localparam logic [31:0] ADDR_INT_CLEAR    = 32'hffff0fb8;

  // ----------------------------------------------------------------
  // compare slots
  // ----------------------------------------------------------------
  localparam int          CMP_W     = 16;
  localparam int          NUM_CMP   = 8;
  localparam int          NUM_OUT   = 4;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // slot order: pair1 first/second/third/length, pair2 first/second/third/length
  localparam logic [31:0] CMP_ADDR [NUM_CMP] = '{
    ADDR_PAIR1_FIRST, ADDR_PAIR1_SECOND, ADDR_PAIR1_THIRD, ADDR_PAIR1_LENGTH,
    ADDR_PAIR2_FIRST, ADDR_PAIR2_SECOND, ADDR_PAIR2_THIRD, ADDR_PAIR2_LENGTH
  };

  // per output (two, three, four, five): slot that sets and slot that clears
  localparam logic [2:0] SET_SLOT [NUM_OUT] = '{3'h0, 3'h3, 3'h4, 3'h7};
  localparam logic [2:0] CLR_SLOT [NUM_OUT] = '{3'h1, 3'h2, 3'h5, 3'h6};

  // output level bits in the status word
  localparam int OUT_TWO   = 0;
  localparam int OUT_THREE = 1;
  localparam int OUT_FOUR  = 2;
  localparam int OUT_FIVE  = 3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        tick;
    logic [15:0] count;
  } timer_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_type;

endpackage

// ---- design/pwm_pair_compare_outputs.sv ----
// compare and length stage driving pulse outputs two to five
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module pwm_pair_compare_outputs (
  // clock, reset and enable
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RSTN_I,
  input  wire logic                   CE_I,
  // avalon-mm slave
  input  wire pwm_pair_pkg::bus_req_type BUS_I,
  output logic [31:0]                 AVS_READDATA_O,
  output logic                        AVS_WAITREQUEST_O,
  // shared pulse timer
  input  wire pwm_pair_pkg::timer_type TIMER_I,
  // pulse outputs and interrupt acknowledge
  output logic                        PULSE_OUT_TWO_O,
  output logic                        PULSE_OUT_THREE_O,
  output logic                        PULSE_OUT_FOUR_O,
  output logic                        PULSE_OUT_FIVE_O,
  output logic                        INT_CLEAR_O
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // bit 3 flags a hit, bits 2:0 carry the slot
  function automatic logic [3:0] cmp_slot(input logic [31:0] addr);
    logic [3:0] res;
    res = 4'h0;
    for (int k = 0; k < pwm_pair_pkg::NUM_CMP; k++) begin
      if (addr == pwm_pair_pkg::CMP_ADDR[k]) begin
        res = {1'b1, 3'(k)};
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  function automatic logic hit(input logic [15:0] cmp, input pwm_pair_pkg::timer_type t);
    return t.tick && (cmp == t.count);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]      cmp [pwm_pair_pkg::NUM_CMP];
  logic [3:0]       out_level;
  logic             busy;
  logic [31:0]      read_word;
  logic             int_clear;
  logic [3:0]       slot;
  logic             req;
  logic             wr_commit;
  logic [3:0]       next_level;

  assign slot      = cmp_slot(BUS_I.address);
  assign req       = BUS_I.read || BUS_I.write;
  assign wr_commit = CE_I && BUS_I.write && !busy;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // every request is answered on its second edge: one cycle to look up,
  // one with waitrequest low; this keeps readdata straight from a flop
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      busy <= 1'b1;
    end else if (CE_I) begin
      busy <= !(req && busy);
    end
  end

  always_comb begin
    read_word = pwm_pair_pkg::READ_ZERO;
    if (slot[3]) begin
      read_word = {16'h0000, cmp[slot[2:0]]};
    end else if (BUS_I.address == pwm_pair_pkg::ADDR_OUT_STATUS) begin
      read_word = {28'h0000000, out_level};
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      AVS_READDATA_O <= pwm_pair_pkg::READ_ZERO;
    end else if (CE_I && BUS_I.read && busy) begin
      AVS_READDATA_O <= read_word;
    end
  end

  // ----------------------------------------------------------------
  // compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int k = 0; k < pwm_pair_pkg::NUM_CMP; k++) begin
        cmp[k] <= pwm_pair_pkg::REG_RESET;
      end
    end else if (wr_commit && slot[3]) begin
      cmp[slot[2:0]] <= merge_lanes(cmp[slot[2:0]], BUS_I.writedata, BUS_I.byteenable);
    end
  end

  // ----------------------------------------------------------------
  // interrupt acknowledge
  // ----------------------------------------------------------------
  // write data and byte enables are ignored: any write to ADDR_INT_CLEAR acknowledges
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      int_clear <= 1'b0;
    end else if (CE_I) begin
      int_clear <= wr_commit && (BUS_I.address == pwm_pair_pkg::ADDR_INT_CLEAR);
    end
  end

  // ----------------------------------------------------------------
  // pulse outputs
  // ----------------------------------------------------------------
  // when set and clear match on the same tick the clear wins, so a pulse
  // whose edges are programmed equal stays low instead of glitching high
  always_comb begin
    next_level = out_level;
    for (int k = 0; k < pwm_pair_pkg::NUM_OUT; k++) begin
      if (hit(cmp[pwm_pair_pkg::CLR_SLOT[k]], TIMER_I)) begin
        next_level[k] = 1'b0;
      end else if (hit(cmp[pwm_pair_pkg::SET_SLOT[k]], TIMER_I)) begin
        next_level[k] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      out_level <= 4'h0;
    end else if (CE_I) begin
      out_level <= next_level;
    end
  end

  assign PULSE_OUT_TWO_O   = out_level[pwm_pair_pkg::OUT_TWO];
  assign PULSE_OUT_THREE_O = out_level[pwm_pair_pkg::OUT_THREE];
  assign PULSE_OUT_FOUR_O  = out_level[pwm_pair_pkg::OUT_FOUR];
  assign PULSE_OUT_FIVE_O  = out_level[pwm_pair_pkg::OUT_FIVE];
  assign AVS_WAITREQUEST_O = busy;
  assign INT_CLEAR_O       = int_clear;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic tk;
  logic [15:0] cnt;
  assign tk  = CE_I && TIMER_I.tick;
  assign cnt = TIMER_I.count;

  // per-output match flags, gated like the level flop so that a frozen
  // clock enable reads as no match at all
  logic [3:0] set_hit;
  logic [3:0] clr_hit;
  always_comb begin
    set_hit = 4'h0;
    clr_hit = 4'h0;
    for (int k = 0; k < pwm_pair_pkg::NUM_OUT; k++) begin
      set_hit[k] = CE_I && hit(cmp[pwm_pair_pkg::SET_SLOT[k]], TIMER_I);
      clr_hit[k] = CE_I && hit(cmp[pwm_pair_pkg::CLR_SLOT[k]], TIMER_I);
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  // ----------------------------------------------------------------
  // pulse set and clear
  // ----------------------------------------------------------------
  // set checks exclude an equal clear value, since the clear wins there

  out2_set_a: assert property (tk && cnt == cmp[0] && cnt != cmp[1] |=> PULSE_OUT_TWO_O)
    else $error("output two not set on first compare match");
  out2_clear_a: assert property (tk && cnt == cmp[1] |=> !PULSE_OUT_TWO_O)
    else $error("output two not cleared on second compare match");
  out3_clear_a: assert property (tk && cnt == cmp[2] |=> !PULSE_OUT_THREE_O)
    else $error("output three not cleared on third compare match");
  out3_set_a: assert property (tk && cnt == cmp[3] && cnt != cmp[2] |=> PULSE_OUT_THREE_O)
    else $error("output three not set on length match");
  out4_set_a: assert property (tk && cnt == cmp[4] && cnt != cmp[5] |=> PULSE_OUT_FOUR_O)
    else $error("output four not set on first compare match");
  out4_clear_a: assert property (tk && cnt == cmp[5] |=> !PULSE_OUT_FOUR_O)
    else $error("output four not cleared on second compare match");
  out5_clear_a: assert property (tk && cnt == cmp[6] |=> !PULSE_OUT_FIVE_O)
    else $error("output five not cleared on third compare match");
  out5_set_a: assert property (tk && cnt == cmp[7] && cnt != cmp[6] |=> PULSE_OUT_FIVE_O)
    else $error("output five not set on length match");

  sequence clear_write_s;
    CE_I && BUS_I.write && !AVS_WAITREQUEST_O && BUS_I.address == pwm_pair_pkg::ADDR_INT_CLEAR;
  endsequence
  int_ack_pulse_a: assert property (clear_write_s |=> INT_CLEAR_O ##1 !INT_CLEAR_O)
    else $error("interrupt clear pulse missing or too long");
  int_ack_cause_a: assert property ($rose(INT_CLEAR_O) |-> $past(wr_commit))
    else $error("interrupt clear pulse without a bus write");

  levels_hold_a: assert property (!tk |=> $stable(out_level))
    else $error("outputs changed without a timer tick");
  bus_answer_a: assert property (CE_I && req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("bus request not answered on the next edge");

  // ----------------------------------------------------------------
  // bus read path and handshake spacing
  // ----------------------------------------------------------------
  // idle waitrequest stays high so a slow master never sees a stale answer
  bus_idle_wait_a: assert property (CE_I && !req |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low without a request");

  bus_one_wait_a: assert property (CE_I && !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low for more than one cycle");

  read_data_a: assert property (CE_I && BUS_I.read && AVS_WAITREQUEST_O
    |=> AVS_READDATA_O == $past(read_word))
    else $error("read data not captured from the addressed register");

  status_read_a: assert property (CE_I && BUS_I.read && AVS_WAITREQUEST_O
    && BUS_I.address == pwm_pair_pkg::ADDR_OUT_STATUS
    |=> AVS_READDATA_O == {28'h0000000, $past(out_level)})
    else $error("status read does not show the output levels");

  clear_read_a: assert property (CE_I && BUS_I.read && AVS_WAITREQUEST_O
    && BUS_I.address == pwm_pair_pkg::ADDR_INT_CLEAR
    |=> AVS_READDATA_O == pwm_pair_pkg::READ_ZERO)
    else $error("interrupt clear register read not zero");

  unmapped_read_a: assert property (CE_I && BUS_I.read && AVS_WAITREQUEST_O && !slot[3]
    && BUS_I.address != pwm_pair_pkg::ADDR_OUT_STATUS
    |=> AVS_READDATA_O == pwm_pair_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  cmp_store_a: assert property (wr_commit && slot[3] && BUS_I.byteenable[1:0] == 2'b11
    |=> cmp[$past(slot[2:0])] == $past(BUS_I.writedata[15:0]))
    else $error("full-lane write not stored in the compare slot");

  // ----------------------------------------------------------------
  // clock enable and level hold
  // ----------------------------------------------------------------
  // a low enable must freeze the handshake too, or a request would be
  // answered while the rest of the block stands still
  ce_freeze_a: assert property (!CE_I |=> $stable(out_level) && $stable(busy)
    && $stable(AVS_READDATA_O) && $stable(int_clear))
    else $error("state moved while the clock enable was low");

  int_ack_idle_a: assert property (!(wr_commit
    && BUS_I.address == pwm_pair_pkg::ADDR_INT_CLEAR) |=> !INT_CLEAR_O)
    else $error("interrupt clear pulse without a clear write");

  out2_hold_a: assert property (!set_hit[0] && !clr_hit[0]
    |=> $stable(PULSE_OUT_TWO_O))
    else $error("output two moved without a match");

  out3_hold_a: assert property (!set_hit[1] && !clr_hit[1]
    |=> $stable(PULSE_OUT_THREE_O))
    else $error("output three moved without a match");

  out4_hold_a: assert property (!set_hit[2] && !clr_hit[2]
    |=> $stable(PULSE_OUT_FOUR_O))
    else $error("output four moved without a match");

  out5_hold_a: assert property (!set_hit[3] && !clr_hit[3]
    |=> $stable(PULSE_OUT_FIVE_O))
    else $error("output five moved without a match");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  // a full pulse, a length-driven rise, an acknowledge, a read and a
  // tick swallowed by a low enable
  out2_pulse_c: cover property ($rose(PULSE_OUT_TWO_O) ##[1:100] $fell(PULSE_OUT_TWO_O));
  ce_freeze_c: cover property (!CE_I && TIMER_I.tick);
  out5_rise_c: cover property ($rose(PULSE_OUT_FIVE_O));
  int_ack_c: cover property (clear_write_s);
  read_done_c: cover property (BUS_I.read && !AVS_WAITREQUEST_O && slot[3]);

endmodule

// ---- dv/pulse_load_model.sv ----
// passive load model counting rising edges on the four pulse outputs
`timescale 1ns/1ps
module pulse_load_model (
  // clock and load pins
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,
  // observed edges
  output logic      [7:0] rises_o
);
  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  logic [3:0] prev = 4'h0;
  initial rises_o = 8'h00;
  // a load only sees levels, so it counts what it would switch on
  always @(posedge clk_i) begin
    rises_o <= rises_o + 8'($countones(level_i & ~prev));
    prev    <= level_i;
  end
endmodule

// ---- dv/pwm_pair_compare_outputs_tb.sv ----
// self-checking bench for the pulse-pair compare stage
`timescale 1ns/1ps
module pwm_pair_compare_outputs_tb;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic                      clk_sys = 1'b0;
  logic                      rstn = 1'b0;
  pwm_pair_pkg::bus_req_type bus = '0;
  pwm_pair_pkg::timer_type   timer = '{1'b0, 16'hffff};
  logic [31:0]               rdata;
  logic                      waitreq;
  logic                      int_clr;
  logic [3:0]                outs;
  logic [7:0]                rises;
  logic                      ce = 1'b1;
  logic [3:0]                be_sel = 4'hf;
  int                        miscompares = 0;
  int                        num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  pwm_pair_compare_outputs dut_u (
    .CLK_SYS_I(clk_sys), .RSTN_I(rstn), .CE_I(ce), .BUS_I(bus),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .TIMER_I(timer),
    .PULSE_OUT_TWO_O(outs[0]), .PULSE_OUT_THREE_O(outs[1]),
    .PULSE_OUT_FOUR_O(outs[2]), .PULSE_OUT_FIVE_O(outs[3]), .INT_CLEAR_O(int_clr));
  pulse_load_model load_u (.clk_i(clk_sys), .level_i(outs), .rises_o(rises));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one edge passes first so a release and a new request never share a time step
  task automatic bus_xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    bus <= '{~wr, wr, a, d, be_sel};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      check("bus answer", 32'h0, 32'h1);
      final_report();
    end
    q = rdata;
    bus <= '0;
  endtask
  task automatic tick(input logic [15:0] c);
    @(posedge clk_sys);
    timer <= '{1'b1, c};
    @(posedge clk_sys);
    timer <= '{1'b0, 16'hffff};
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reg_scenario();
    logic [31:0] q;
    for (int k = 0; k < 8; k++) begin
      bus_xfer(1'b0, pwm_pair_pkg::CMP_ADDR[k], 32'h0, q);
      check("reset value", 32'h0, q);
      bus_xfer(1'b1, pwm_pair_pkg::CMP_ADDR[k], {16'hdead, 16'h0100 + 16'(k)}, q);
      bus_xfer(1'b0, pwm_pair_pkg::CMP_ADDR[k], 32'h0, q);
      check("read back", {16'h0, 16'h0100 + 16'(k)}, q);
    end
    // upper lane only, then slot zero is restored for the pulse scenario
    be_sel <= 4'h2;
    bus_xfer(1'b1, pwm_pair_pkg::ADDR_PAIR1_FIRST, 32'h0000aa55, q);
    be_sel <= 4'hf;
    bus_xfer(1'b0, pwm_pair_pkg::ADDR_PAIR1_FIRST, 32'h0, q);
    check("upper lane write", 32'h0000aa00, q);
    bus_xfer(1'b1, pwm_pair_pkg::ADDR_PAIR1_FIRST, 32'h00000100, q);
    bus_xfer(1'b0, 32'hffff0fbc, 32'h0, q);
    check("unmapped read", 32'h0, q);
  endtask
  task automatic pulse_scenario();
    logic [31:0] q;
    logic [3:0]  exp;
    int          set_slot [4] = '{0, 3, 4, 7};
    int          clr_slot [4] = '{1, 2, 5, 6};
    exp = 4'h0;
    for (int k = 0; k < 4; k++) begin
      tick(16'h0100 + 16'(set_slot[k]));
      exp[k] = 1'b1;
      check("level after set", 32'(exp), 32'(outs));
      bus_xfer(1'b0, pwm_pair_pkg::ADDR_OUT_STATUS, 32'h0, q);
      check("status word", 32'(exp), q);
      tick(16'h0abc);
      check("level held", 32'(exp), 32'(outs));
      tick(16'h0100 + 16'(clr_slot[k]));
      exp[k] = 1'b0;
      check("level after clear", 32'(exp), 32'(outs));
    end
    @(posedge clk_sys);
    check("load rises", 32'h4, 32'(rises));
  endtask
  // equal set and clear values leave the output low; a low enable swallows a tick
  task automatic corner_scenario();
    logic [31:0] q;
    bus_xfer(1'b1, pwm_pair_pkg::ADDR_PAIR1_SECOND, 32'h00000100, q);
    tick(16'h0100);
    check("equal set and clear", 32'h0, 32'(outs));
    bus_xfer(1'b1, pwm_pair_pkg::ADDR_PAIR1_SECOND, 32'h00000101, q);
    @(posedge clk_sys);
    ce <= 1'b0;
    tick(16'h0100);
    check("frozen by enable", 32'h0, 32'(outs));
    @(posedge clk_sys);
    ce <= 1'b1;
    tick(16'h0100);
    check("set after enable", 32'h1, 32'(outs));
    tick(16'h0101);
    check("clear after enable", 32'h0, 32'(outs));
  endtask
  // data must not matter, so one all-zero and one patterned write
  task automatic int_scenario();
    logic [31:0] q;
    logic        seen;
    for (int k = 0; k < 2; k++) begin
      bus_xfer(1'b1, pwm_pair_pkg::ADDR_INT_CLEAR, k ? 32'h0000a5a5 : 32'h0, q);
      seen = 1'b0;
      repeat (3) begin
        #1 seen |= (int_clr === 1'b1);
        @(posedge clk_sys);
      end
      check("interrupt clear pulse", 32'h1, 32'(seen));
    end
    bus_xfer(1'b0, pwm_pair_pkg::ADDR_INT_CLEAR, 32'h0, q);
    check("clear reads zero", 32'h0, q);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_scenario();
    pulse_scenario();
    corner_scenario();
    int_scenario();
    final_report();
  end
endmodule
